// ---- core/crg_cfg.sv ----
// Clock/reset generator configuration: synthesizer, REALTIME_INTERRUPT decimal divider and watchdog control.
// Assumes a one-cycle register port clocked by the bus clock; read data appear one cycle later.
//
// Operation
// - Synth register readable; writes ignored while loop selected.
// - Accepted synth write restarts lock detector.
// - VCO, PLL ratios from synthesizer fields; bus ratio fixed at 2.
// - Decimal mode divider is (low+1) times prescale.
// - Watchdog control layout, readable any time.
// - Stop bit free special, else set-only.
// - Window and rate write-once outside special mode.
// - Zero writes outside special mode keep value but consume write.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module crg_cfg #(
  parameter logic [2:0] WD_RATE_RESET = 3'h0, // Device option reset of timeout rate.
  parameter logic       WD_WIN_RESET  = 1'b0  // Device option reset of window mode.
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Device mode and loop status
  input  wire logic        special_mode,
  input  wire logic        loop_lock_raw,
  // Clock controls
  output logic             system_clock_from_loop_select,
  output logic      [1:0]  vco_gain_range,
  output logic      [6:0]  vco_num,
  output logic      [6:0]  vco_den,
  output logic      [5:0]  pll_den,
  output logic      [6:0]  bus_den,
  output logic             lock_restart,
  output logic             loop_locked,
  // Real-time interrupt divider
  output logic      [23:0] realtime_divider,
  // Watchdog controls
  output logic             window_mode_bit,
  output logic             stop_in_background,
  output logic      [2:0]  timeout_rate_field
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  crg_synth_if sif ();                 // Settings toward the ratio unit.
  logic [5:0] mul_r;                   // Multiplier field.
  logic [1:0] vco_r;                   // Gain range.
  logic [5:0] reference_divider_field_r;                // Reference divider field.
  logic [4:0] post_divider_field_r;               // Post divider field.
  logic       sel_r;                   // Loop clock select.
  logic [7:0] rti_r;                   // Realtime rate field and decimal mode.
  logic       win_r;                   // Window mode.
  logic       stop_r;                  // Stop in background.
  logic [2:0] rate_r;                  // Timeout rate.
  logic       once_r;                  // One-time write used.
  logic [6:0] lock_cnt_r;              // Lock settle counter.
  logic       restart_r;               // Lock restart pulse.
  logic [7:0] rdata_nxt;               // Read mux.
  logic       synth_wr;                // Accepted synthesizer write.
  logic       wd_wr;                   // Watchdog write.
  logic       wd_open;                 // Window and rate may change.

  // Decode helper used by every write path.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign synth_wr = reg_wr && !sel_r && (hit(reg_addr, crg_pkg::OFS_SYNTH) ||
                    hit(reg_addr, crg_pkg::OFS_REFDV) || hit(reg_addr, crg_pkg::OFS_POSTDV));
  assign wd_wr    = reg_wr && hit(reg_addr, crg_pkg::OFS_WDOG);
  // The mask bit shields window and rate, not the stop bit, and leaves the one-time write unused.
  assign wd_open  = wd_wr && !reg_wdata[crg_pkg::WD_MASK_BIT] && (special_mode || !once_r);

  // ----------------------------------------------------------------------
  // Synthesizer registers
  // ----------------------------------------------------------------------
  // Writes are refused while the loop drives the system clock, since
  // retuning a running clock source would glitch the whole chip.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mul_r     <= 6'h00;
      vco_r     <= 2'h0;
      reference_divider_field_r  <= 6'h00;
      post_divider_field_r <= 5'h00;
    end else if (synth_wr) begin
      if (hit(reg_addr, crg_pkg::OFS_SYNTH)) begin
        mul_r <= reg_wdata[crg_pkg::SYN_MUL_LSB +: 6];
        vco_r <= reg_wdata[crg_pkg::SYN_VCO_LSB +: 2];
      end else if (hit(reg_addr, crg_pkg::OFS_REFDV)) begin
        reference_divider_field_r <= reg_wdata[crg_pkg::REF_DIV_LSB +: 6];
      end else begin
        post_divider_field_r <= reg_wdata[crg_pkg::POST_DIV_LSB +: 5];
      end
    end
  end

  // Clock select; not itself write protected.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_r <= 1'b0;
    end else if (reg_wr && hit(reg_addr, crg_pkg::OFS_CLKSEL)) begin
      sel_r <= reg_wdata[crg_pkg::SEL_LOOP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Lock detector
  // ----------------------------------------------------------------------
  // Every accepted synthesizer write restarts the settle count.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_cnt_r <= 7'h00;
      restart_r  <= 1'b0;
    end else begin
      restart_r <= synth_wr;
      if (synth_wr || !loop_lock_raw) begin
        lock_cnt_r <= 7'h00;
      end else if (lock_cnt_r != 7'(crg_pkg::LOCK_SETTLE)) begin
        lock_cnt_r <= lock_cnt_r + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Realtime interrupt rate
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rti_r            <= crg_pkg::RST_BYTE;
      realtime_divider <= 24'h000000;
    end else begin
      if (reg_wr && hit(reg_addr, crg_pkg::OFS_RTICTL)) begin
        rti_r <= reg_wdata;
      end
      // Binary mode is handled elsewhere; only decimal mode yields a count here.
      if (rti_r[crg_pkg::RTI_DEC_BIT]) begin
        realtime_divider <= 24'(({20'h00000, rti_r[3:0]} + 24'h000001) *
                                crg_pkg::PRESCALE[rti_r[6:4]]);
      end else begin
        realtime_divider <= 24'h000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      win_r  <= WD_WIN_RESET;
      stop_r <= 1'b0;
      rate_r <= WD_RATE_RESET;
      once_r <= 1'b0;
    end else begin
      if (wd_wr) begin
        if (special_mode) begin
          stop_r <= reg_wdata[crg_pkg::WD_STOP_BIT];
        end else if (reg_wdata[crg_pkg::WD_STOP_BIT]) begin
          stop_r <= 1'b1;
        end
      end
      if (wd_open) begin
        if (special_mode) begin
          win_r  <= reg_wdata[crg_pkg::WD_WIN_BIT];
          rate_r <= reg_wdata[crg_pkg::WD_RATE_LSB +: 3];
        end else begin
          once_r <= 1'b1;
          if (reg_wdata[crg_pkg::WD_WIN_BIT]) begin
            win_r <= 1'b1;
          end
          if (reg_wdata[crg_pkg::WD_RATE_LSB +: 3] != crg_pkg::RATE_NONE) begin
            rate_r <= reg_wdata[crg_pkg::WD_RATE_LSB +: 3];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(reg_addr, crg_pkg::OFS_SYNTH)) begin
      rdata_nxt = {vco_r, mul_r};
    end else if (hit(reg_addr, crg_pkg::OFS_REFDV)) begin
      rdata_nxt = {2'h0, reference_divider_field_r};
    end else if (hit(reg_addr, crg_pkg::OFS_POSTDV)) begin
      rdata_nxt = {3'h0, post_divider_field_r};
    end else if (hit(reg_addr, crg_pkg::OFS_CLKSEL)) begin
      rdata_nxt = {sel_r, 7'h00};
    end else if (hit(reg_addr, crg_pkg::OFS_RTICTL)) begin
      rdata_nxt = rti_r;
    end else if (hit(reg_addr, crg_pkg::OFS_LOCK)) begin
      rdata_nxt = {loop_locked, special_mode, once_r, 5'h00};
    end else if (hit(reg_addr, crg_pkg::OFS_WDOG)) begin
      rdata_nxt = {win_r, stop_r, 3'h0, rate_r};
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Ratio unit and outputs
  // ----------------------------------------------------------------------
  assign sif.mul      = mul_r;
  assign sif.ref_div  = reference_divider_field_r;
  assign sif.post_div = post_divider_field_r;

  crg_ratio u_ratio (
    .clk     (clk),
    .reset_n (reset_n),
    .sif     (sif)
  );

  assign vco_num                       = sif.vco_num;
  assign vco_den                       = sif.vco_den;
  assign pll_den                       = sif.pll_den;
  assign bus_den                       = sif.bus_den;
  assign system_clock_from_loop_select = sel_r;
  assign vco_gain_range                = vco_r;
  assign lock_restart                  = restart_r;
  assign loop_locked                   = (lock_cnt_r == 7'(crg_pkg::LOCK_SETTLE));
  assign window_mode_bit               = win_r;
  assign stop_in_background            = stop_r;
  assign timeout_rate_field            = rate_r;
endmodule

// ---- core/crg_pkg.sv ----
// Package of the clock/reset generator configuration block: offsets, fields, reset values.
// Assumes a byte-wide register port inside the clock domain of the bus clock.
package crg_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_SYNTH   = 8'h00; // Synthesizer multiplier and gain range.
  localparam logic [7:0] OFS_REFDV   = 8'h01; // Reference divider.
  localparam logic [7:0] OFS_POSTDV  = 8'h02; // Post divider.
  localparam logic [7:0] OFS_CLKSEL  = 8'h03; // System clock select.
  localparam logic [7:0] OFS_RTICTL  = 8'h04; // Real-time interrupt rate and mode.
  localparam logic [7:0] OFS_LOCK    = 8'h05; // Lock status and mode status.
  localparam logic [7:0] OFS_WDOG    = 8'h08; // Watchdog control.
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SYN_MUL_LSB   = 0;  // Multiplier field, six bits.
  localparam int SYN_VCO_LSB   = 6;  // VCO gain range, two bits.
  localparam int REF_DIV_LSB   = 0;  // Reference divider, six bits.
  localparam int POST_DIV_LSB  = 0;  // Post divider, five bits.
  localparam int SEL_LOOP_BIT  = 7;  // Loop clock selected as system clock.
  localparam int RTI_DEC_BIT   = 7;  // Decimal divide mode.
  localparam int WD_WIN_BIT    = 7;  // Window mode.
  localparam int WD_STOP_BIT   = 6;  // Stop in background.
  localparam int WD_MASK_BIT   = 5;  // Write mask, write only.
  localparam int WD_RATE_LSB   = 0;  // Timeout rate, three bits.
  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00; // Reset of the realtime interrupt control register.
  localparam logic [2:0] RATE_NONE    = 3'h0;  // Rate code that leaves rate unchanged outside special mode.
  localparam logic [1:0] VCO_RESERVED = 2'h2;  // Gain range code software must avoid.
  localparam int LOCK_SETTLE = 64;             // Cycles until the lock detector reports lock.
  localparam int DIV_W       = 24;             // Width of the decimal divider result.
  // Decimal prescales for codes 0 to 7.
  localparam logic [23:0] PRESCALE [8] = '{24'h0003E8, 24'h0007D0, 24'h001388, 24'h002710,
                                           24'h004E20, 24'h00C350, 24'h0186A0, 24'h030D40};
endpackage

// ---- core/crg_synth_if.sv ----
// Interface carrying synthesizer settings from the register file to the ratio unit.
// Assumes both ends are in one clock domain.
`timescale 1ns/10ps
interface crg_synth_if;
  logic [5:0] mul;  // Multiplier field.
  logic [5:0] ref_div; // Reference divider field.
  logic [4:0] post_div; // Post divider field.
  logic [6:0] vco_num; // Output: VCO numerator, 2 x (mul + 1).
  logic [6:0] vco_den; // Output: VCO denominator, ref_div + 1.
  logic [5:0] pll_den; // Output: PLL divider, 2 x post_div or 1.
  logic [6:0] bus_den; // Output: bus divider from PLL output to bus clock.
  modport regs  (output mul, ref_div, post_div, input vco_num, vco_den, pll_den, bus_den);
  modport ratio (input mul, ref_div, post_div, output vco_num, vco_den, pll_den, bus_den);
endinterface

// ---- core/crg_ratio.sv ----
// Ratio unit: turns the synthesizer fields into VCO and PLL ratios; the bus clock ratio is fixed at 2.
// Assumes fields held stable in flip-flops of the register file.
`timescale 1ns/10ps
module crg_ratio (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Settings and ratios
  crg_synth_if.ratio sif
);
  // ----------------------------------------------------------------------
  // Ratio registers
  // ----------------------------------------------------------------------
  // Registered so the analog loop sees glitch-free control words.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sif.vco_num <= 7'h02;
      sif.vco_den <= 7'h01;
      sif.pll_den <= 6'h01;
      sif.bus_den <= 7'h02;
    end else begin
      sif.vco_num <= {sif.mul + 6'h01, 1'b0};
      sif.vco_den <= {1'b0, sif.ref_div} + 7'h01;
      // A zero post divider means divide by one.
      sif.pll_den <= (sif.post_div == 5'h00) ? 6'h01 : {sif.post_div, 1'b0};
      sif.bus_den <= 7'h02;
    end
  end
endmodule

// ---- sim/crg_cfg_asserts.sv ----
// Checker for the clock/reset generator configuration block, watching only its top-level ports.
// Assumes one clock domain and the synchronous active-low reset of the block itself.
`timescale 1ns/10ps
module crg_cfg_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Mode, clock controls and watchdog fields
  input wire logic       special_mode,
  input wire logic       system_clock_from_loop_select,
  input wire logic [1:0] vco_gain_range,
  input wire logic [6:0] vco_num,
  input wire logic [5:0] pll_den,
  input wire logic       lock_restart,
  input wire logic       loop_locked,
  input wire logic       window_mode_bit,
  input wire logic       stop_in_background,
  input wire logic [2:0] timeout_rate_field
);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_synth_lockout: assert property (reg_wr && reg_addr <= crg_pkg::OFS_POSTDV && system_clock_from_loop_select
    |=> !lock_restart) else $error("synth write accepted while loop selected");
  a_restart_pulse: assert property (reg_wr && reg_addr <= crg_pkg::OFS_POSTDV && !system_clock_from_loop_select
    |=> lock_restart) else $error("no lock restart after synth write");
  a_lock_cleared: assert property (lock_restart |=> !loop_locked) else $error("lock held over restart");
  a_vco_ratio: assert property (reg_wr && reg_addr == crg_pkg::OFS_SYNTH && !system_clock_from_loop_select
    |-> ##2 vco_num == {$past(reg_wdata[5:0], 2), 1'b0} + 7'h02) else $error("vco numerator wrong");
  a_post_ratio: assert property (reg_wr && reg_addr == crg_pkg::OFS_POSTDV && !system_clock_from_loop_select
    |-> ##2 pll_den == (($past(reg_wdata[4:0], 2) == 5'h00) ? 6'h01 : {$past(reg_wdata[4:0], 2), 1'b0}))
    else $error("post divider wrong");
  a_wd_readback: assert property (reg_rd && reg_addr == crg_pkg::OFS_WDOG |=> reg_rdata ==
    {$past(window_mode_bit), $past(stop_in_background), 3'h0, $past(timeout_rate_field)})
    else $error("watchdog read data wrong");
  a_stop_sticky: assert property (!special_mode && stop_in_background |=> stop_in_background)
    else $error("stop bit cleared in normal mode");
  a_zero_rate: assert property (!special_mode && reg_wr && reg_addr == crg_pkg::OFS_WDOG
    && reg_wdata[2:0] == 3'h0 |=> $stable(timeout_rate_field)) else $error("zero rate write took effect");
  a_mask_keep: assert property (reg_wr && reg_addr == crg_pkg::OFS_WDOG && reg_wdata[crg_pkg::WD_MASK_BIT]
    |=> $stable(window_mode_bit) && $stable(timeout_rate_field)) else $error("masked write changed fields");
  // Software must never leave the reserved gain code in the loop; the bench keeps to legal codes.
  a_gain_legal: assert property (vco_gain_range != crg_pkg::VCO_RESERVED) else $error("reserved gain range in use");
endmodule
bind crg_cfg crg_cfg_asserts u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
  .system_clock_from_loop_select(system_clock_from_loop_select), .vco_gain_range(vco_gain_range), .vco_num(vco_num),
  .pll_den(pll_den), .lock_restart(lock_restart), .loop_locked(loop_locked), .window_mode_bit(window_mode_bit),
  .stop_in_background(stop_in_background), .timeout_rate_field(timeout_rate_field));

// ---- sim/crg_cfg_bench.sv ----
// Self-checking bench for the clock/reset generator configuration block.
// Assumes the byte register port answers reads in the cycle after the strobe.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module crg_cfg_bench;
  logic        clk, reset_n, reg_wr, reg_rd, special_mode, loop_lock_raw, sel, rst_pulse, locked, win, stop;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  gain;
  logic [6:0]  vnum, vden, bden;
  logic [5:0]  pden;
  logic [23:0] rdiv;
  logic [2:0]  rate;
  int          n_errors = 0;
  int          samples_checked = 0;
  crg_cfg i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode), .loop_lock_raw(loop_lock_raw),
    .system_clock_from_loop_select(sel), .vco_gain_range(gain), .vco_num(vnum), .vco_den(vden), .pll_den(pden),
    .bus_den(bden), .lock_restart(rst_pulse), .loop_locked(locked), .realtime_divider(rdiv),
    .window_mode_bit(win), .stop_in_background(stop), .timeout_rate_field(rate));
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------------------------------------------
  // Bus and run-control tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data are looked at only in the single cycle where they stand.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("read data", e, reg_rdata)
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  task automatic finish_test();
    $display("Mismatches %0d of %0d comparisons", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic s_reset_values();
    `CHK("vco_num", 7'h02, vnum)
    `CHK("bus_den", 7'h02, bden)
    rd(crg_pkg::OFS_WDOG, 8'h00);
  endtask
  // Ratios follow the fields, and a post divider of zero means divide by one.
  task automatic s_synth();
    wr(crg_pkg::OFS_SYNTH, 8'h45);
    rd(crg_pkg::OFS_SYNTH, 8'h45);
    `CHK("vco_num", 7'h0C, vnum)
    `CHK("gain range", 2'h1, gain)
    wr(crg_pkg::OFS_REFDV, 8'h03);
    wr(crg_pkg::OFS_POSTDV, 8'h00);
    repeat (2) @(posedge clk);
    #1 `CHK("vco_den", 7'h04, vden)
    `CHK("pll_den zero", 6'h01, pden)
    wr(crg_pkg::OFS_POSTDV, 8'h05);
    repeat (2) @(posedge clk);
    #1 `CHK("pll_den", 6'h0A, pden)
  endtask
  // Lock is reached, lost on an accepted write, and writes bounce while the loop clocks the system.
  task automatic s_lock_select();
    int i;
    // Inputs move only on a rising edge.
    @(posedge clk);
    loop_lock_raw <= 1'b1;
    for (i = 0; i < 200 && locked !== 1'b1; i++) @(posedge clk);
    if (locked !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    wr(crg_pkg::OFS_SYNTH, 8'h45);
    // The restart pulse stands only in the cycle after the accepted write.
    #1 `CHK("lock restart", 1'b1, rst_pulse)
    @(posedge clk);
    #1 `CHK("locked", 1'b0, locked)
    wr(crg_pkg::OFS_CLKSEL, 8'h80);
    #1 `CHK("select", 1'b1, sel)
    wr(crg_pkg::OFS_SYNTH, 8'h12);
    wr(crg_pkg::OFS_POSTDV, 8'h1F);
    rd(crg_pkg::OFS_SYNTH, 8'h45);
    `CHK("pll_den held", 6'h0A, pden)
    wr(crg_pkg::OFS_CLKSEL, 8'h00);
  endtask
  // Every prescale code, with the low field stepping down from its top value.
  task automatic s_rti();
    logic [3:0] lo;
    for (int i = 0; i < 8; i++) begin
      lo = 4'hF - 4'(2 * i);
      wr(crg_pkg::OFS_RTICTL, {1'b1, 3'(i), lo});
      repeat (2) @(posedge clk);
      #1 `CHK("rti divider", crg_pkg::PRESCALE[i] * (24'(lo) + 24'h000001), rdiv)
    end
    // Without decimal mode this block yields no decimal count.
    wr(crg_pkg::OFS_RTICTL, 8'h7F);
    repeat (2) @(posedge clk);
    #1 `CHK("rti binary", 24'h000000, rdiv)
  endtask
  // Normal mode: masked write is free, then one write sticks and the stop bit only sets.
  task automatic s_wd_normal();
    wr(crg_pkg::OFS_WDOG, 8'h27);
    rd(crg_pkg::OFS_WDOG, 8'h00);
    wr(crg_pkg::OFS_WDOG, 8'h85);
    rd(crg_pkg::OFS_WDOG, 8'h85);
    wr(crg_pkg::OFS_WDOG, 8'h02);
    rd(crg_pkg::OFS_WDOG, 8'h85);
    wr(crg_pkg::OFS_WDOG, 8'h40);
    wr(crg_pkg::OFS_WDOG, 8'h00);
    rd(crg_pkg::OFS_WDOG, 8'hC5);
    `CHK("window", 1'b1, win)
    `CHK("stop", 1'b1, stop)
    `CHK("rate", 3'h5, rate)
  endtask
  // A zero write uses up the single write without changing anything.
  task automatic s_wd_zero();
    do_reset();
    wr(crg_pkg::OFS_WDOG, 8'h00);
    wr(crg_pkg::OFS_WDOG, 8'h83);
    rd(crg_pkg::OFS_WDOG, 8'h00);
  endtask
  // Special mode: fields rewrite freely, the mask still protects window and rate.
  task automatic s_special();
    @(posedge clk);
    special_mode <= 1'b1;
    wr(crg_pkg::OFS_WDOG, 8'hC7);
    rd(crg_pkg::OFS_WDOG, 8'hC7);
    wr(crg_pkg::OFS_WDOG, 8'h02);
    rd(crg_pkg::OFS_WDOG, 8'h02);
    wr(crg_pkg::OFS_WDOG, 8'hA5);
    rd(crg_pkg::OFS_WDOG, 8'h02);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
  endtask
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    special_mode = 1'b0;
    loop_lock_raw = 1'b0;
    do_reset();
    s_reset_values();
    s_synth();
    s_lock_select();
    s_rti();
    s_wd_normal();
    s_wd_zero();
    s_special();
    finish_test();
  end
endmodule
